// File: dv/dll_off_to_on_switch_sequence_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "dsw_cfg.svh"
module dll_off_to_on_switch_sequence_tb;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic start = 1'b0;
  logic zq_en = 1'b0;
  logic clk_stable = 1'b0;
  logic odt_feat_on = 1'b0;
  logic odt_req = 1'b0;
  logic term = 1'b0;
  logic prev_cke = 1'b1;
  logic [13:0] new_mr0 = 14'h0000;
  logic [13:0] new_mr1 = 14'h0000;
  logic [13:0] new_mr2 = 14'h0000;
  logic busy_ff, clk_change_ok_ff, done_ff, in_sr_ff, dll_en_ff, dll_locked_ff, ready_ff, zq_busy_ff;
  wire [3:0] err_ff;
  wire [3:0] flt_err_ff;
  logic [21:0] seen_q[$];
  int at_q[$];
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  int done_at = 0;
  dsw_if pins_if ();
  dsw_if flt_if ();
  dsw_ctrl u_dsw_ctrl (.clock(clock), .srst(srst), .ce(ce), .start(start), .zq_en(zq_en), .clk_stable(clk_stable),
    .odt_feat_on(odt_feat_on), .odt_req(odt_req), .new_mr0(new_mr0), .new_mr1(new_mr1), .new_mr2(new_mr2),
    .busy_ff(busy_ff), .clk_change_ok_ff(clk_change_ok_ff), .done_ff(done_ff), .pins(pins_if.ctrl));
  dsw_mem u_dsw_mem (.clock(clock), .srst(srst), .ce(ce), .pins(pins_if.mem), .in_sr_ff(in_sr_ff),
    .dll_en_ff(dll_en_ff), .dll_locked_ff(dll_locked_ff), .ready_ff(ready_ff), .zq_busy_ff(zq_busy_ff),
    .err_cke_ff(err_ff[3]), .err_odt_ff(err_ff[2]), .err_mrd_ff(err_ff[1]), .err_early_ff(err_ff[0]));
  // Second device fed by a deliberately faulty driver
  dsw_mem u_dsw_mem_flt (.clock(clock), .srst(srst), .ce(ce), .pins(flt_if.mem), .in_sr_ff(), .dll_en_ff(),
    .dll_locked_ff(), .ready_ff(), .zq_busy_ff(), .err_cke_ff(flt_err_ff[3]), .err_odt_ff(flt_err_ff[2]),
    .err_mrd_ff(flt_err_ff[1]), .err_early_ff(flt_err_ff[0]));
  dsw_props u_dsw_props (.clock(clock), .srst(srst), .cke(pins_if.cke), .odt(pins_if.odt), .cs_n(pins_if.cs_n),
    .ras_n(pins_if.ras_n), .cas_n(pins_if.cas_n), .we_n(pins_if.we_n), .ba(pins_if.ba), .addr(pins_if.addr));
  ////////////////////////////////////////////////////////////////
  // Free-running clock
  initial begin
    forever #10 clock = ~clock;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict
  // Bounded wait on change-ok (0) or done (1); running out ends the run
  task automatic wait_hi(input int which, input int lim);
    int k;
    k = 0;
    while ((which == 0 ? clk_change_ok_ff : done_ff) !== 1'b1) begin
      @(posedge clock);
      k++;
      if (k > lim) begin
        chk(which == 0 ? clk_change_ok_ff : done_ff, 1'b1);
        give_verdict();
      end
    end
  endtask : wait_hi
  // Log commands and the exit edge with their cycle numbers
  always @(posedge clock) begin
    cyc++;
    if ({pins_if.cs_n, pins_if.ras_n, pins_if.cas_n, pins_if.we_n} != `DSW_CMD_NOP || (pins_if.cke && !prev_cke)) begin
      seen_q.push_back({pins_if.cke, pins_if.cs_n, pins_if.ras_n, pins_if.cas_n, pins_if.we_n, pins_if.ba, pins_if.addr});
      at_q.push_back(cyc);
    end
    prev_cke = pins_if.cke;
    if (done_ff === 1'b1) done_at = cyc;
    if (in_sr_ff === 1'b1) chk(pins_if.odt, odt_req & ~odt_feat_on);
  end
  ////////////////////////////////////////////////////////////////
  // Faulty side: one pin pattern per call, held n edges
  task automatic drv(input logic k, input logic [3:0] c, input logic [2:0] b, input logic [13:0] a, input logic o,
      input int n);
    repeat (n) begin
      @(posedge clock);
      flt_if.cke <= k;
      {flt_if.cs_n, flt_if.ras_n, flt_if.cas_n, flt_if.we_n} <= c;
      flt_if.ba <= b;
      flt_if.addr <= a;
      flt_if.odt <= o;
    end
  endtask : drv
  // One full switch; expectations built from the required order
  task automatic run_seq(input int n);
    logic [21:0] exp_a[8];
    logic [21:0] msk_a[8];
    logic [13:0] m0, m1, m2;
    m0 = 14'($urandom);
    m1 = 14'($urandom);
    m2 = 14'($urandom);
    exp_a = '{{1'b1, `DSW_CMD_PRE, 3'h0, 14'h0400}, {1'b0, `DSW_CMD_REF, 17'h0_0000}, {1'b1, `DSW_CMD_NOP, 17'h0_0000},
      {1'b1, `DSW_CMD_MRS, `DSW_BA_MR1, m1 & 14'h3ffe}, {1'b1, `DSW_CMD_MRS, `DSW_BA_MR0, m0 | 14'h0100},
      {1'b1, `DSW_CMD_MRS, `DSW_BA_MR2, m2}, {1'b1, `DSW_CMD_MRS, `DSW_BA_MR0, m0 & 14'h3eff},
      {1'b1, `DSW_CMD_ZQ, 3'h0, 14'h0400}};
    msk_a = '{22'h3e_0400, 22'h3e_0000, 22'h3e_0000, 22'h3f_ffff, 22'h3f_ffff, 22'h3f_ffff, 22'h3f_ffff, 22'h3e_0400};
    seen_q.delete();
    at_q.delete();
    @(posedge clock);
    new_mr0 <= m0;
    new_mr1 <= m1;
    new_mr2 <= m2;
    zq_en <= n[0];
    odt_feat_on <= term;
    odt_req <= 1'($urandom);
    clk_stable <= 1'b0;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    wait_hi(0, 50);
    chk(pins_if.cke, 1'b0);
    // Late clock on some runs, stray start while busy on the last
    repeat (n) @(posedge clock);
    clk_stable <= 1'b1;
    start <= (n == 3);
    if (n == 1) begin
      // Low clock enable must park the sequencer in the clock-change state
      ce <= 1'b0;
      repeat (4) @(posedge clock);
      chk(clk_change_ok_ff, 1'b1);
      ce <= 1'b1;
    end
    if (n == 2) begin
      @(posedge clock);
      clk_stable <= 1'b0;
      @(posedge clock);
      clk_stable <= 1'b1;
    end
    @(posedge clock);
    start <= 1'b0;
    wait_hi(1, 2000);
    @(posedge clock);
    chk(seen_q.size(), 7 + n[0]);
    for (int k = 0; k < seen_q.size() && k < 8; k++) chk(seen_q[k] & msk_a[k], exp_a[k] & msk_a[k]);
    if (seen_q.size() == 7 + n[0]) begin
      chk(at_q[1] - at_q[0] >= `DSW_TRP_CYC, 1);
      chk(at_q[2] - at_q[1] >= `DSW_TCKSRE_CYC + `DSW_TCKSRX_CYC, 1);
      chk(at_q[3] - at_q[2] >= `DSW_TXS_CYC, 1);
      chk(at_q[4] - at_q[3] >= `DSW_TMRD_NCK, 1);
      chk(at_q[6] - at_q[5] >= `DSW_TMRD_NCK, 1);
      chk(done_at - at_q[4] >= `DSW_TDLLK_NCK, 1);
      chk(done_at - at_q[6] >= `DSW_TMOD_NCK, 1);
      if (n[0]) chk(at_q[7] - at_q[6] >= `DSW_TMOD_NCK, 1);
      if (n[0]) chk(done_at - at_q[7] >= `DSW_TZQOPER_NCK, 1);
    end
    chk({busy_ff, dll_en_ff, dll_locked_ff, ready_ff, zq_busy_ff, err_ff}, 9'h0e0);
    term = |{m1[2], m1[6], m1[9], m2[10:9]};
  endtask : run_seq
  ////////////////////////////////////////////////////////////////
  // Main sequence: faulty driver first, then four switches
  initial begin
    flt_if.cke = 1'b1;
    flt_if.odt = 1'b0;
    {flt_if.cs_n, flt_if.ras_n, flt_if.cas_n, flt_if.we_n} = `DSW_CMD_NOP;
    flt_if.ba = 3'h0;
    flt_if.addr = 14'h0000;
    void'($urandom(32'h0000_f316));
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    drv(1'b1, `DSW_CMD_MRS, `DSW_BA_MR1, 14'h0004, 1'b0, 1);
    drv(1'b1, `DSW_CMD_NOP, 3'h0, 14'h0000, 1'b0, 4);
    drv(1'b0, `DSW_CMD_REF, 3'h0, 14'h0000, 1'b0, 1);
    drv(1'b0, `DSW_CMD_NOP, 3'h0, 14'h0000, 1'b1, 2);
    drv(1'b1, `DSW_CMD_NOP, 3'h0, 14'h0000, 1'b0, 10);
    chk(flt_err_ff, 4'h4);
    drv(1'b1, `DSW_CMD_MRS, `DSW_BA_MR1, 14'h0000, 1'b0, 1);
    drv(1'b1, `DSW_CMD_NOP, 3'h0, 14'h0000, 1'b0, 3);
    drv(1'b1, `DSW_CMD_MRS, `DSW_BA_MR0, 14'h0100, 1'b0, 1);
    drv(1'b1, `DSW_CMD_NOP, 3'h0, 14'h0000, 1'b0, 2);
    drv(1'b1, `DSW_CMD_MRS, `DSW_BA_MR2, 14'h0000, 1'b0, 1);
    drv(1'b1, `DSW_CMD_NOP, 3'h0, 14'h0000, 1'b0, 3);
    drv(1'b1, `DSW_CMD_ZQ, 3'h0, 14'h0000, 1'b0, 1);
    drv(1'b0, `DSW_CMD_NOP, 3'h0, 14'h0000, 1'b0, 2);
    drv(1'b1, `DSW_CMD_NOP, 3'h0, 14'h0000, 1'b0, 3);
    chk(flt_err_ff, 4'hf);
    for (int n = 0; n < 4; n++) run_seq(n);
    give_verdict();
  end
endmodule : dll_off_to_on_switch_sequence_tb
`default_nettype wire

// File: dv/dsw_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "dsw_cfg.svh"
module dsw_props (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Memory pins
  input wire logic cke,
  input wire logic odt,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] ba,
  input wire logic [13:0] addr
);
  localparam int XS = `DSW_TXS_CYC;
  logic [3:0] cmd;
  logic mrs, mr1_w, dll_rst, zq, hold_ff, pre_ff, cke_q_ff;
  logic [15:0] lock_ff;
  logic [7:0] since_ff;
  // Decoded commands
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign mrs = cke && cmd == `DSW_CMD_MRS;
  assign mr1_w = mrs && ba == `DSW_BA_MR1;
  assign dll_rst = mrs && ba == `DSW_BA_MR0 && addr[`DSW_MR0_DLL_RST_BIT];
  assign zq = cke && cmd == `DSW_CMD_ZQ;
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////
  // Lock window, reloaded by every DLL reset
  always_ff @(posedge clock) begin
    if (srst) lock_ff <= 16'h0000;
    else if (dll_rst) lock_ff <= 16'(`DSW_TDLLK_NCK);
    else if (lock_ff != 16'h0000) lock_ff <= lock_ff - 16'h0001;
  end
  // Exit-to-lock span; clock enable must not drop inside it
  always_ff @(posedge clock) begin
    if (srst) begin
      hold_ff <= 1'b0;
      cke_q_ff <= 1'b1;
    end else begin
      cke_q_ff <= cke;
      if (cke && !cke_q_ff) hold_ff <= 1'b1;
      else if (lock_ff == 16'h0001) hold_ff <= 1'b0;
    end
  end
  // Precharge seen, and edges since the last mode write (saturating)
  always_ff @(posedge clock) begin
    if (srst) begin
      pre_ff <= 1'b0;
      since_ff <= 8'hff;
    end else begin
      if (cke && cmd == `DSW_CMD_PRE && addr[`DSW_A10_BIT]) pre_ff <= 1'b1;
      else if (!cke) pre_ff <= 1'b0;
      since_ff <= mrs ? 8'h01 : (since_ff == 8'hff ? since_ff : since_ff + 8'h01);
    end
  end
  ////////////////////////////////////////////////////////////////
  a_pre_before_sre: assert property ($fell(cke) |-> cmd == `DSW_CMD_REF && pre_ff)
    else $error("self refresh entry without precharge all");
  a_sr_nop_only: assert property (!cke && !$past(cke) |-> cmd == `DSW_CMD_NOP || cs_n)
    else $error("command issued inside self refresh");
  a_sr_min_low: assert property ($rose(cke) |-> !$past(cke, 2))
    else $error("self refresh exit too soon");
  a_mr1_dll_on: assert property (mr1_w |-> !addr[`DSW_MR1_DLL_OFF_BIT])
    else $error("DLL left off in mode register 1");
  a_xs_before_mr1: assert property (mr1_w |-> $past(cke, XS))
    else $error("mode register 1 written before exit delay");
  a_reset_after_mr1: assert property (dll_rst |-> $past(mr1_w, 4))
    else $error("DLL reset not four edges after DLL enable");
  a_mrs_spacing: assert property (mrs |=> !mrs [*3])
    else $error("mode writes closer than four edges");
  a_cke_until_lock: assert property (hold_ff || lock_ff != 16'h0000 |-> cke)
    else $error("clock enable low before lock time");
  a_zq_after_mod: assert property (zq |-> since_ff >= 8'h0c)
    else $error("calibration before update delay");
  a_no_short_zq: assert property (lock_ff != 16'h0000 |-> !(zq && !addr[`DSW_A10_BIT]))
    else $error("short calibration while locking");
  cover property (dll_rst);
  cover property (zq);
  cover property ($fell(cke));
  cover property (hold_ff && odt);
endmodule : dsw_props
`default_nettype wire

// File: verilog/dsw_cfg.svh
`ifndef DSW_CFG_SVH
`define DSW_CFG_SVH

// Clock period of the controller clock, picoseconds
`define DSW_CLK_PS 20000

// Command codes {cs_n, ras_n, cas_n, we_n}
`define DSW_CMD_MRS 4'h0
`define DSW_CMD_REF 4'h1
`define DSW_CMD_PRE 4'h2
`define DSW_CMD_ZQ 4'h6
`define DSW_CMD_NOP 4'h7

// Address bit positions
`define DSW_MR1_DLL_OFF_BIT 0
`define DSW_MR0_DLL_RST_BIT 8
`define DSW_A10_BIT 10
`define DSW_MR1_RTT_B0 2
`define DSW_MR1_RTT_B1 6
`define DSW_MR1_RTT_B2 9
`define DSW_MR2_RTTWR_LO 9
`define DSW_MR2_RTTWR_HI 10

// Bank address of each mode register
`define DSW_BA_MR0 3'h0
`define DSW_BA_MR1 3'h1
`define DSW_BA_MR2 3'h2

// Nanosecond times, plain defaults
`define DSW_TRP_NS 15
`define DSW_TCKSRE_NS 10
`define DSW_TCKSRX_NS 10
`define DSW_TXS_NS 170

// Clock-count times
`define DSW_TMRD_NCK 4
`define DSW_TMOD_NCK 12
`define DSW_TDLLK_NCK 512
`define DSW_TZQOPER_NCK 256

// Rounded-up cycle counts
`define DSW_NS2CYC(ns) (((ns) * 1000 + `DSW_CLK_PS - 1) / `DSW_CLK_PS)
`define DSW_TRP_CYC `DSW_NS2CYC(`DSW_TRP_NS)
`define DSW_TCKSRE_CYC `DSW_NS2CYC(`DSW_TCKSRE_NS)
`define DSW_TCKSRX_CYC `DSW_NS2CYC(`DSW_TCKSRX_NS)
`define DSW_TXS_CYC `DSW_NS2CYC(`DSW_TXS_NS)

`endif

// File: verilog/dsw_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "dsw_cfg.svh"
// What this block does
// - Precharge all, termination off before entry
// - Enter self refresh, wait entry time
// - Stable new clock before exit
// - Clock enable high until lock
// - ODT low if termination enabled
// - ODT free if termination disabled
// - Write MR1 A0 zero, DLL on
// - After spacing write MR0 A8 one
// - Then reprogram mode registers
// - Optional long calibration after update delay
// - Next command after final update delay
// - No locked-DLL command before lock
// - Wait calibration time if issued
// - Spacings count actual clock edges; here the counters advance only on edges with ce high
// - Nanoseconds rounded up to cycles
module dsw_ctrl (
  // Clock and control
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  // Sequence control
  input wire logic start,
  input wire logic zq_en,
  input wire logic clk_stable,
  // Termination handling
  input wire logic odt_feat_on,
  input wire logic odt_req,
  // Mode register values for the new frequency
  input wire logic [13:0] new_mr0,
  input wire logic [13:0] new_mr1,
  input wire logic [13:0] new_mr2,
  // Status
  output logic busy_ff,
  output logic clk_change_ok_ff,
  output logic done_ff,
  // Memory-side pins
  dsw_if.ctrl pins
);
  ////////////////////////////////////////////////////////////
  dsw_pkg::dsw_state_e state_ff;
  dsw_pkg::dsw_state_e nxt_state;
  dsw_pkg::dsw_cnt_t cnt_ff;
  dsw_pkg::dsw_cnt_t nxt_cnt;
  dsw_pkg::dsw_cnt_t lock_cnt_ff;
  logic cke_ff;
  logic odt_ff;
  logic [3:0] cmd_ff;
  logic [2:0] ba_ff;
  dsw_pkg::dsw_addr_t addr_ff;
  logic wait_end;

  assign pins.cke = cke_ff;
  assign pins.odt = odt_ff;
  assign pins.cs_n = cmd_ff[3];
  assign pins.ras_n = cmd_ff[2];
  assign pins.cas_n = cmd_ff[1];
  assign pins.we_n = cmd_ff[0];
  assign pins.ba = ba_ff;
  assign pins.addr = addr_ff;

  // Wait ends on the count's last edge, so the next command lands N+1 edges on for a load of N
  assign wait_end = cnt_ff == 16'h0001;

  ////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = (cnt_ff != 16'h0000) ? cnt_ff - 16'h0001 : cnt_ff;
    case (state_ff)
      dsw_pkg::ST_IDLE: begin
        nxt_state = start ? dsw_pkg::ST_PREA : state_ff;
      end
      dsw_pkg::ST_PREA: begin
        nxt_state = dsw_pkg::ST_W_RP;
        nxt_cnt = 16'(`DSW_TRP_CYC);
      end
      dsw_pkg::ST_W_RP: begin
        nxt_state = wait_end ? dsw_pkg::ST_SRE : state_ff;
      end
      dsw_pkg::ST_SRE: begin
        nxt_state = dsw_pkg::ST_W_CKSRE;
        nxt_cnt = 16'(`DSW_TCKSRE_CYC);
      end
      dsw_pkg::ST_W_CKSRE: begin
        nxt_state = wait_end ? dsw_pkg::ST_CLK_CHG : state_ff;
      end
      // stable clock, then exit clock time
      dsw_pkg::ST_CLK_CHG: begin
        if (clk_stable) begin
          nxt_state = dsw_pkg::ST_W_CKSRX;
          nxt_cnt = 16'(`DSW_TCKSRX_CYC);
        end
      end
      dsw_pkg::ST_W_CKSRX: begin
        nxt_state = !clk_stable ? dsw_pkg::ST_CLK_CHG : (wait_end ? dsw_pkg::ST_SRX : state_ff);
      end
      dsw_pkg::ST_SRX: begin
        nxt_state = dsw_pkg::ST_W_XS;
        nxt_cnt = 16'(`DSW_TXS_CYC);
      end
      dsw_pkg::ST_W_XS: begin
        nxt_state = wait_end ? dsw_pkg::ST_MR1 : state_ff;
      end
      dsw_pkg::ST_MR1: begin
        nxt_state = dsw_pkg::ST_W_MRD1;
        nxt_cnt = 16'(`DSW_TMRD_NCK - 1);
      end
      dsw_pkg::ST_W_MRD1: begin
        nxt_state = wait_end ? dsw_pkg::ST_MR0_RST : state_ff;
      end
      dsw_pkg::ST_MR0_RST: begin
        nxt_state = dsw_pkg::ST_W_MRD2;
        nxt_cnt = 16'(`DSW_TMRD_NCK - 1);
      end
      dsw_pkg::ST_W_MRD2: begin
        nxt_state = wait_end ? dsw_pkg::ST_MR2 : state_ff;
      end
      dsw_pkg::ST_MR2: begin
        nxt_state = dsw_pkg::ST_W_MRD3;
        nxt_cnt = 16'(`DSW_TMRD_NCK - 1);
      end
      dsw_pkg::ST_W_MRD3: begin
        nxt_state = wait_end ? dsw_pkg::ST_MR0 : state_ff;
      end
      dsw_pkg::ST_MR0: begin
        nxt_state = dsw_pkg::ST_W_MOD;
        nxt_cnt = 16'(`DSW_TMOD_NCK - 1);
      end
      dsw_pkg::ST_W_MOD: begin
        nxt_state = wait_end ? (zq_en ? dsw_pkg::ST_ZQ : dsw_pkg::ST_W_LOCK) : state_ff;
      end
      dsw_pkg::ST_ZQ: begin
        nxt_state = dsw_pkg::ST_W_ZQ;
        nxt_cnt = 16'(`DSW_TZQOPER_NCK - 1);
      end
      dsw_pkg::ST_W_ZQ: begin
        nxt_state = wait_end ? dsw_pkg::ST_W_LOCK : state_ff;
      end
      // hold until lock time is over
      dsw_pkg::ST_W_LOCK: begin
        nxt_state = (lock_cnt_ff == 16'h0000) ? dsw_pkg::ST_DONE : state_ff;
      end
      dsw_pkg::ST_DONE: nxt_state = dsw_pkg::ST_IDLE;
      default: begin
        nxt_state = dsw_pkg::ST_IDLE;
        nxt_cnt = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_ff <= dsw_pkg::ST_IDLE;
      cnt_ff <= 16'h0000;
    end else if (ce) begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // lock time runs from the DLL reset
  always_ff @(posedge clock) begin
    if (srst) begin
      lock_cnt_ff <= 16'h0000;
    end else if (ce) begin
      if (state_ff == dsw_pkg::ST_MR0_RST) begin
        lock_cnt_ff <= 16'(`DSW_TDLLK_NCK);
      end else if (lock_cnt_ff != 16'h0000) begin
        lock_cnt_ff <= lock_cnt_ff - 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Pin command, one cycle behind the state so spacing is kept
  always_ff @(posedge clock) begin
    if (srst) begin
      cmd_ff <= `DSW_CMD_NOP;
      ba_ff <= 3'h0;
      addr_ff <= 14'h0000;
    end else if (ce) begin
      cmd_ff <= `DSW_CMD_NOP;
      ba_ff <= 3'h0;
      addr_ff <= 14'h0000;
      case (state_ff)
        dsw_pkg::ST_PREA: begin
          cmd_ff <= `DSW_CMD_PRE;
          addr_ff[`DSW_A10_BIT] <= 1'b1;
        end
        dsw_pkg::ST_SRE: cmd_ff <= `DSW_CMD_REF;
        dsw_pkg::ST_MR1: begin
          cmd_ff <= `DSW_CMD_MRS;
          ba_ff <= `DSW_BA_MR1;
          addr_ff <= new_mr1;
          addr_ff[`DSW_MR1_DLL_OFF_BIT] <= 1'b0;
        end
        dsw_pkg::ST_MR0_RST: begin
          cmd_ff <= `DSW_CMD_MRS;
          ba_ff <= `DSW_BA_MR0;
          addr_ff <= new_mr0;
          addr_ff[`DSW_MR0_DLL_RST_BIT] <= 1'b1;
        end
        dsw_pkg::ST_MR2: begin
          cmd_ff <= `DSW_CMD_MRS;
          ba_ff <= `DSW_BA_MR2;
          addr_ff <= new_mr2;
        end
        dsw_pkg::ST_MR0: begin
          cmd_ff <= `DSW_CMD_MRS;
          ba_ff <= `DSW_BA_MR0;
          addr_ff <= new_mr0;
          addr_ff[`DSW_MR0_DLL_RST_BIT] <= 1'b0;
        end
        dsw_pkg::ST_ZQ: begin
          cmd_ff <= `DSW_CMD_ZQ;
          addr_ff[`DSW_A10_BIT] <= 1'b1;
        end
        default: cmd_ff <= `DSW_CMD_NOP;
      endcase
    end
  end

  // cke low only inside self refresh
  always_ff @(posedge clock) begin
    if (srst) begin
      cke_ff <= 1'b1;
    end else if (ce) begin
      cke_ff <= (state_ff == dsw_pkg::ST_SRE) ? 1'b0 : ((state_ff == dsw_pkg::ST_SRX) ? 1'b1 : cke_ff);
    end
  end

  // forced low when termination was on
  // user level when it was off
  always_ff @(posedge clock) begin
    if (srst) begin
      odt_ff <= 1'b0;
    end else if (ce) begin
      odt_ff <= (busy_ff || start) ? (odt_req && !odt_feat_on) : odt_req;
    end
  end

  // Status flags
  always_ff @(posedge clock) begin
    if (srst) begin
      busy_ff <= 1'b0;
      clk_change_ok_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (ce) begin
      busy_ff <= nxt_state != dsw_pkg::ST_IDLE;
      // Clock may only move while parked here
      clk_change_ok_ff <= nxt_state == dsw_pkg::ST_CLK_CHG;
      done_ff <= nxt_state == dsw_pkg::ST_DONE;
    end
  end
endmodule : dsw_ctrl
`default_nettype wire

// File: verilog/dsw_if.sv
`timescale 1ns/100ps
`default_nettype none
interface dsw_if;
  logic cke;
  logic odt;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [2:0] ba;
  logic [13:0] addr;
  modport ctrl (output cke, odt, cs_n, ras_n, cas_n, we_n, ba, addr);
  modport mem (input cke, odt, cs_n, ras_n, cas_n, we_n, ba, addr);
endinterface : dsw_if
`default_nettype wire

// File: verilog/dsw_mem.sv
`timescale 1ns/100ps
`default_nettype none
`include "dsw_cfg.svh"
module dsw_mem (
  // Clock and control
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  // Memory-side pins
  dsw_if.mem pins,
  // Status
  output logic in_sr_ff,
  output logic dll_en_ff,
  output logic dll_locked_ff,
  output logic ready_ff,
  output logic zq_busy_ff,
  // Sticky protocol errors
  output logic err_cke_ff,
  output logic err_odt_ff,
  output logic err_mrd_ff,
  output logic err_early_ff
);
  ////////////////////////////////////////////////////////////
  logic [3:0] cmd;
  logic cke_prev_ff;
  logic is_mrs;
  logic sre;
  logic srx;
  logic [2:0] rtt_nom_ff;
  logic [1:0] rtt_wr_ff;
  logic odt_feat_ff;
  logic locking;
  dsw_pkg::dsw_cnt_t lock_cnt_ff;
  dsw_pkg::dsw_cnt_t gap_ff;
  dsw_pkg::dsw_cnt_t mod_cnt_ff;
  dsw_pkg::dsw_cnt_t zq_cnt_ff;

  // Command decode; deselect reads as nop
  assign cmd = pins.cs_n ? `DSW_CMD_NOP : {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
  assign is_mrs = pins.cke && (cmd == `DSW_CMD_MRS);
  assign sre = cke_prev_ff && !pins.cke && (cmd == `DSW_CMD_REF);
  assign srx = in_sr_ff && pins.cke;
  assign locking = lock_cnt_ff != 16'h0000;

  ////////////////////////////////////////////////////////////
  // Self refresh state and cke history
  always_ff @(posedge clock) begin
    if (srst) begin
      in_sr_ff <= 1'b0;
      cke_prev_ff <= 1'b1;
    end else if (ce) begin
      cke_prev_ff <= pins.cke;
      if (sre) begin
        in_sr_ff <= 1'b1;
      end else if (srx) begin
        in_sr_ff <= 1'b0;
      end
    end
  end

  // Termination settings, latched as features at entry
  always_ff @(posedge clock) begin
    if (srst) begin
      rtt_nom_ff <= 3'h0;
      rtt_wr_ff <= 2'h0;
      odt_feat_ff <= 1'b0;
    end else if (ce) begin
      if (is_mrs && pins.ba == `DSW_BA_MR1) begin
        rtt_nom_ff <= {pins.addr[`DSW_MR1_RTT_B2], pins.addr[`DSW_MR1_RTT_B1], pins.addr[`DSW_MR1_RTT_B0]};
      end
      if (is_mrs && pins.ba == `DSW_BA_MR2) begin
        rtt_wr_ff <= pins.addr[`DSW_MR2_RTTWR_HI:`DSW_MR2_RTTWR_LO];
      end
      if (sre) begin
        odt_feat_ff <= (rtt_nom_ff != 3'h0) || (rtt_wr_ff != 2'h0);
      end
    end
  end

  // DLL enable by mode register 1
  always_ff @(posedge clock) begin
    if (srst) begin
      dll_en_ff <= 1'b0;
    end else if (ce && is_mrs && pins.ba == `DSW_BA_MR1) begin
      dll_en_ff <= !pins.addr[`DSW_MR1_DLL_OFF_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      lock_cnt_ff <= 16'h0000;
      dll_locked_ff <= 1'b0;
    end else if (ce) begin
      if (is_mrs && pins.ba == `DSW_BA_MR0 && pins.addr[`DSW_MR0_DLL_RST_BIT]) begin
        lock_cnt_ff <= 16'(`DSW_TDLLK_NCK);
        dll_locked_ff <= 1'b0;
      end else if (locking) begin
        lock_cnt_ff <= lock_cnt_ff - 16'h0001;
        dll_locked_ff <= (lock_cnt_ff == 16'h0001) && dll_en_ff;
      end else if (!dll_en_ff) begin
        dll_locked_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      gap_ff <= 16'hffff;
    end else if (ce) begin
      if (is_mrs) begin
        gap_ff <= 16'h0000;
      end else if (gap_ff != 16'hffff) begin
        gap_ff <= gap_ff + 16'h0001;
      end
    end
  end

  // ready once mode update delay is over
  always_ff @(posedge clock) begin
    if (srst) begin
      mod_cnt_ff <= 16'h0000;
      ready_ff <= 1'b1;
    end else if (ce) begin
      if (is_mrs) begin
        mod_cnt_ff <= 16'(`DSW_TMOD_NCK - 1);
        ready_ff <= 1'b0;
      end else if (mod_cnt_ff != 16'h0000) begin
        mod_cnt_ff <= mod_cnt_ff - 16'h0001;
        ready_ff <= (mod_cnt_ff == 16'h0001) && !in_sr_ff;
      end else begin
        ready_ff <= !in_sr_ff && !sre;
      end
    end
  end

  // Long calibration busy time
  always_ff @(posedge clock) begin
    if (srst) begin
      zq_cnt_ff <= 16'h0000;
      zq_busy_ff <= 1'b0;
    end else if (ce) begin
      if (pins.cke && cmd == `DSW_CMD_ZQ && pins.addr[`DSW_A10_BIT]) begin
        zq_cnt_ff <= 16'(`DSW_TZQOPER_NCK - 1);
        zq_busy_ff <= 1'b1;
      end else if (zq_cnt_ff != 16'h0000) begin
        zq_cnt_ff <= zq_cnt_ff - 16'h0001;
      end else begin
        zq_busy_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Protocol error flags, sticky until reset
  always_ff @(posedge clock) begin
    if (srst) begin
      err_cke_ff <= 1'b0;
      err_odt_ff <= 1'b0;
      err_mrd_ff <= 1'b0;
      err_early_ff <= 1'b0;
    end else if (ce) begin
      if (locking && !pins.cke) begin
        err_cke_ff <= 1'b1;
      end
      if (odt_feat_ff && (locking || in_sr_ff) && pins.odt) begin
        err_odt_ff <= 1'b1;
      end
      if (is_mrs && gap_ff < 16'(`DSW_TMRD_NCK - 1)) begin
        err_mrd_ff <= 1'b1;
      end
      if (locking && pins.cke && (cmd == `DSW_CMD_ZQ) && !pins.addr[`DSW_A10_BIT]) begin
        err_early_ff <= 1'b1;
      end
    end
  end
endmodule : dsw_mem
`default_nettype wire

// File: verilog/dsw_pkg.sv
`default_nettype none
package dsw_pkg;
  typedef logic [15:0] dsw_cnt_t;
  typedef logic [13:0] dsw_addr_t;
  typedef enum logic [4:0] {
    ST_IDLE, ST_PREA, ST_W_RP, ST_SRE, ST_W_CKSRE, ST_CLK_CHG, ST_W_CKSRX,
    ST_SRX, ST_W_XS, ST_MR1, ST_W_MRD1, ST_MR0_RST, ST_W_MRD2, ST_MR2,
    ST_W_MRD3, ST_MR0, ST_W_MOD, ST_ZQ, ST_W_ZQ, ST_W_LOCK, ST_DONE
  } dsw_state_e;
endpackage : dsw_pkg
`default_nettype wire
